/* rtl/irq_evt_pkg.sv */
// package of the interrupt and event transfer system: sizes, register map,
// field positions, reset values, response counts and bus carriers.
// assumes a single 10 MHz clock and an APB master with 32-bit data.
package irq_evt_pkg;

  // ==========================================================================
  // sizes
  localparam int NODES = 64;
  localparam int NODE_W = 6;
  localparam int CHANS = 8;
  localparam int CHAN_W = 3;
  localparam int ERU_N = 4;
  localparam int SHARED_N = 16;
  localparam int SHARED_BASE = 56;
  localparam int ERU_NODE_BASE = 52;
  localparam int ADDR_W = 24;
  localparam int PRIO_W = 4;
  localparam int CNT_W = 8;

  // ==========================================================================
  // response times in cpu clocks
  localparam int RESP_FAST = 7;
  localparam int RESP_SLOW = 11;
  localparam int RESP_W = 4;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] OFF_NODE = 12'h000;
  localparam logic [11:0] OFF_SRCSEL = 12'h100;
  localparam logic [11:0] OFF_CHCTL = 12'h120;
  localparam logic [11:0] OFF_CHSRC = 12'h140;
  localparam logic [11:0] OFF_CHDST = 12'h160;
  localparam logic [11:0] OFF_EDGE = 12'h180;
  localparam logic [11:0] OFF_ROUTE = 12'h184;
  localparam logic [11:0] OFF_PAT = 12'h190;
  localparam logic [11:0] OFF_STAT = 12'h1A0;

  // ==========================================================================
  // field positions
  localparam int NC_REQ = 0;
  localparam int NC_EN = 1;
  localparam int NC_PRIO = 2;
  localparam int NC_ETU = 6;
  localparam int NC_CHAN = 7;
  localparam int CC_CNT = 0;
  localparam int CC_WORD = 8;
  localparam int CC_INCS = 9;
  localparam int CC_INCD = 10;
  localparam int CC_CONT = 11;
  localparam int PT_PAT = 0;
  localparam int PT_MASK = 4;
  localparam int PT_MODE = 8;

  // ==========================================================================
  // reset values
  localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
  localparam logic [11:0] CHCTL_RST = 12'h000;
  localparam logic [31:0] SRCSEL_RST = 32'h0000_0000;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [15:0] ROUTE_RST = 16'h0000;
  localparam logic [9:0] PAT_RST = 10'h300;

  // ==========================================================================
  // gating modes of an output gating unit
  typedef enum logic [1:0] {
    GATE_ALWAYS = 2'h0,
    GATE_MATCH = 2'h1,
    GATE_MISS = 2'h2,
    GATE_OFF = 2'h3
  } gate_mode_e;

  // apb request as driven by the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // one data move issued by the event transfer unit
  typedef struct packed {
    logic valid;
    logic word;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
  } move_s;

endpackage : irq_evt_pkg

/* rtl/ptr_mem.sv */
// small pointer memory: two lanes per entry, lane write enables,
// registered read data.
// assumes one write and one read per cycle from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ptr_mem #(
  parameter int HALF_W = 24,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // write port
  input wire logic [1:0] wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [2*HALF_W-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [2*HALF_W-1:0] rd_data
);

  // ==========================================================================
  // storage
  logic [2*HALF_W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || DEPTH > (1 << AW) || HALF_W < 1) begin
      $error("ptr_mem: unusable geometry");
    end
  end

  // lane writes; no reset so this can map onto a register file
  always_ff @(posedge ref_clk) begin
    if (wr_en[0]) begin
      mem[wr_addr][HALF_W-1:0] <= wr_data[HALF_W-1:0];
    end
    if (wr_en[1]) begin
      mem[wr_addr][2*HALF_W-1:HALF_W] <= wr_data[2*HALF_W-1:HALF_W];
    end
  end

  // read data held in a register until the next read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : ptr_mem
`default_nettype wire

/* rtl/irq_evt_system.sv */
// interrupt nodes, priority arbiter, event transfer unit and external
// request router, with an apb register slave.
// assumes same-clock single-cycle request pulses from peripherals and a
// core that follows the suspend and branch outputs.
//
// Summary of operation
// RULE_01 - each node routes to interrupt or transfer
// RULE_02 - interrupt suspends program, branches to vector
// RULE_03 - transfer steals exactly one cpu cycle
// RULE_04 - move byte/word, then bump chosen pointers
// RULE_05 - per-channel counter decrements unless continuous
// RULE_06 - counter zero raises the node's interrupt
// RULE_07 - eight independent transfer channels
// RULE_08 - response takes 7 or 11 clocks
// RULE_09 - 64 nodes: flag, enable, priority
// RULE_10 - shared nodes pick source by select regs
// RULE_11 - router: four inputs, matrix, four gates
// RULE_12 - edge logic detects rising, falling or both
// RULE_13 - gate passes events on pattern match/miss
// RULE_14 - hardware trap served first like interrupt
// RULE_15 - highest enabled pending priority wins
`timescale 1ns/1ps
`default_nettype none
module irq_evt_system
  import irq_evt_pkg::*;
#(
  parameter logic [ADDR_W-1:0] VECT_BASE = 24'h000000, // arbitrary
  parameter logic [ADDR_W-1:0] TRAP_VECT = 24'h000100, // arbitrary
  parameter int VECT_SH = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // apb slave
  input wire apb_req_s apb_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic [NODES-1:0] src_req,
  input wire logic [SHARED_N-1:0] shared_req,
  input wire logic trap_req,
  input wire logic [ERU_N-1:0] ext_pin,
  // core side
  input wire logic jump_cache,
  output logic cpu_suspend,
  output logic irq_branch,
  output logic [ADDR_W-1:0] irq_addr,
  output logic cpu_stall,
  output move_s mv_out,
  output logic [ERU_N-1:0] eru_trig
);

  // ==========================================================================
  // declarations
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_FETCH = 5'b00010,
    S_MOVE = 5'b00100,
    S_WAIT = 5'b01000,
    S_APB = 5'b10000
  } state_e;

  state_e state;
  logic [NODES-1:0] node_flag, node_en, node_etu, src_evt;
  logic [PRIO_W-1:0] node_prio [NODES];
  logic [CHAN_W-1:0] node_chan [NODES];
  logic [11:0] ch_ctl [CHANS];
  logic [31:0] src_sel;
  logic [7:0] edge_cfg;
  logic [15:0] route;
  logic [9:0] pat_cfg [ERU_N];
  logic trap_pend, svc_trap, svc_clear;
  logic [NODE_W-1:0] svc_node;
  logic [CHAN_W-1:0] svc_chan;
  logic [RESP_W-1:0] resp_cnt;
  logic win_found;
  logic [NODE_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_prio;
  logic [ERU_N-1:0] eru_lvl, eru_evt, s1, s2, s3;
  logic apb_acc, apb_go, hit_node, hit_ctl, hit_src, hit_dst, hit_pat, mapped;
  logic [31:0] rd_val;
  logic mem_rd;
  logic [1:0] mem_we;
  logic [CHAN_W-1:0] mem_raddr, mem_waddr;
  logic [2*ADDR_W-1:0] mem_wdata, mem_q;
  logic [ADDR_W-1:0] next_src, next_dst, step;
  logic [CNT_W-1:0] cur_cnt, next_cnt;
  logic cur_cont;

  initial begin
    if (RESP_FAST < 2 || RESP_SLOW >= (1 << RESP_W) || VECT_SH > 8) begin
      $error("irq_evt_system: response counts or vector spacing unusable");
    end
  end

  // ==========================================================================
  // apb decode
  wire logic [11:0] pa = apb_in.paddr;
  assign apb_acc = apb_in.psel && apb_in.penable && !pready;
  assign hit_node = (pa[11:8] == OFF_NODE[11:8]);
  assign hit_ctl = ({pa[11:5], 5'h00} == OFF_CHCTL);
  assign hit_src = ({pa[11:5], 5'h00} == OFF_CHSRC);
  assign hit_dst = ({pa[11:5], 5'h00} == OFF_CHDST);
  assign hit_pat = ({pa[11:4], 4'h0} == OFF_PAT);
  assign mapped = hit_node || hit_ctl || hit_src || hit_dst || hit_pat
    || pa == OFF_SRCSEL || pa == OFF_EDGE || pa == OFF_ROUTE || pa == OFF_STAT;
  // bus only served while no service is starting; heavy request storms stall it
  assign apb_go = apb_acc && state == S_IDLE && !trap_pend && !win_found;
  wire logic apb_wr = apb_go && apb_in.pwrite && mapped;

  // read value of flop-held registers
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_node) begin
      rd_val[NC_REQ] = node_flag[pa[7:2]];
      rd_val[NC_EN] = node_en[pa[7:2]];
      rd_val[NC_PRIO +: PRIO_W] = node_prio[pa[7:2]];
      rd_val[NC_ETU] = node_etu[pa[7:2]];
      rd_val[NC_CHAN +: CHAN_W] = node_chan[pa[7:2]];
    end else if (hit_ctl) begin
      rd_val[11:0] = ch_ctl[pa[4:2]];
    end else if (hit_pat) begin
      rd_val[9:0] = pat_cfg[pa[3:2]];
    end else if (pa == OFF_SRCSEL) begin
      rd_val = src_sel;
    end else if (pa == OFF_EDGE) begin
      rd_val[7:0] = edge_cfg;
    end else if (pa == OFF_ROUTE) begin
      rd_val[15:0] = route;
    end else if (pa == OFF_STAT) begin
      rd_val[12:0] = {trap_pend, state, svc_chan, svc_node[3:0]};
    end
  end

  // ==========================================================================
  // node request sources, shared selection and router outputs
  generate
    for (genvar n = 0; n < NODES; n++) begin : g_node
      if (n >= SHARED_BASE) begin : g_sh
        // shared node takes the source its select nibble names
        assign src_evt[n] = shared_req[src_sel[4*(n-SHARED_BASE) +: 4]]; // RULE_10
      end else if (n >= ERU_NODE_BASE && n < ERU_NODE_BASE + ERU_N) begin : g_eru
        assign src_evt[n] = src_req[n] || eru_trig[n-ERU_NODE_BASE];
      end else begin : g_ded
        assign src_evt[n] = src_req[n];
      end
      // request flag: a new request beats any clear in the same cycle
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          node_flag[n] <= 1'b0;
        end else if (src_evt[n] || (apb_wr && hit_node && pa[7:2] == n
                     && apb_in.pwdata[NC_REQ])) begin
          node_flag[n] <= 1'b1; // RULE_09
        end else if ((svc_clear && !svc_trap && svc_node == n)
                     || (apb_wr && hit_node && pa[7:2] == n)) begin
          node_flag[n] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // arbiter: highest priority value, lowest index on ties
  always_comb begin
    win_found = 1'b0;
    win_idx = '0;
    win_prio = '0;
    for (int i = 0; i < NODES; i++) begin
      if (node_flag[i] && node_en[i] && (!win_found || node_prio[i] > win_prio)) begin
        win_found = 1'b1; // RULE_15
        win_idx = NODE_W'(i);
        win_prio = node_prio[i];
      end
    end
  end

  // ==========================================================================
  // pointer memory and transfer arithmetic
  assign mem_rd = (apb_go && !apb_in.pwrite && (hit_src || hit_dst))
    || (state == S_IDLE && !trap_pend && win_found && node_etu[win_idx]);
  assign mem_raddr = (state == S_IDLE && win_found) ? node_chan[win_idx] : pa[4:2];
  assign mem_waddr = (state == S_FETCH) ? svc_chan : pa[4:2];
  // a non-continuous channel entered with its count at zero moves nothing, so its pointers stay
  assign mem_we = (state == S_FETCH) ? {2{cur_cont || cur_cnt != '0}}
    : {apb_wr && hit_dst, apb_wr && hit_src};
  assign mem_wdata = (state == S_FETCH) ? {next_dst, next_src}
    : {apb_in.pwdata[ADDR_W-1:0], apb_in.pwdata[ADDR_W-1:0]};
  assign cur_cnt = ch_ctl[svc_chan][CC_CNT +: CNT_W];
  assign cur_cont = ch_ctl[svc_chan][CC_CONT];
  assign step = ch_ctl[svc_chan][CC_WORD] ? ADDR_W'(2) : ADDR_W'(1);
  // pointers advance by the moved size, only where enabled
  assign next_src = ch_ctl[svc_chan][CC_INCS] ? mem_q[ADDR_W-1:0] + step
    : mem_q[ADDR_W-1:0]; // RULE_04
  assign next_dst = ch_ctl[svc_chan][CC_INCD] ? mem_q[2*ADDR_W-1:ADDR_W] + step
    : mem_q[2*ADDR_W-1:ADDR_W]; // RULE_04
  assign next_cnt = cur_cont ? cur_cnt : cur_cnt - CNT_W'(1); // RULE_05

  ptr_mem #(
    .HALF_W(ADDR_W),
    .DEPTH(CHANS), // RULE_07
    .AW(CHAN_W)
  ) u_ptr_mem (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_en(mem_rd),
    .rd_addr(mem_raddr),
    .rd_data(mem_q)
  );

  // ==========================================================================
  // node and channel configuration; count and path change on transfer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      node_en <= '0;
      node_etu <= '0;
      node_prio <= '{default: PRIO_RST};
      node_chan <= '{default: '0};
      ch_ctl <= '{default: CHCTL_RST};
    end else begin
      if (apb_wr && hit_node) begin
        node_en[pa[7:2]] <= apb_in.pwdata[NC_EN];
        node_prio[pa[7:2]] <= apb_in.pwdata[NC_PRIO +: PRIO_W];
        node_etu[pa[7:2]] <= apb_in.pwdata[NC_ETU]; // RULE_01
        node_chan[pa[7:2]] <= apb_in.pwdata[NC_CHAN +: CHAN_W];
      end
      if (apb_wr && hit_ctl) begin
        ch_ctl[pa[4:2]] <= apb_in.pwdata[11:0];
      end
      // a non-continuous count already at zero is left alone and only drops the path bit
      if (state == S_FETCH) begin
        if (cur_cont || cur_cnt != '0) begin
          ch_ctl[svc_chan][CC_CNT +: CNT_W] <= next_cnt; // RULE_05
        end
        if (!cur_cont && cur_cnt <= CNT_W'(1)) begin
          node_etu[svc_node] <= 1'b0; // RULE_06
        end
      end
    end
  end

  // ==========================================================================
  // service sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      svc_node <= '0;
      svc_chan <= '0;
      svc_trap <= 1'b0;
      resp_cnt <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (trap_pend) begin
            state <= S_WAIT; // RULE_14
            svc_trap <= 1'b1;
            resp_cnt <= jump_cache ? RESP_W'(RESP_FAST - 1) : RESP_W'(RESP_SLOW - 1);
          end else if (win_found) begin
            svc_node <= win_idx;
            svc_chan <= node_chan[win_idx];
            svc_trap <= 1'b0;
            if (node_etu[win_idx]) begin
              state <= S_FETCH; // RULE_01
            end else begin
              state <= S_WAIT;
              resp_cnt <= jump_cache ? RESP_W'(RESP_FAST - 1)
                : RESP_W'(RESP_SLOW - 1); // RULE_08
            end
          end else if (apb_go && !apb_in.pwrite && (hit_src || hit_dst)) begin
            state <= S_APB;
          end
        end
        S_FETCH: state <= S_MOVE;
        S_MOVE: state <= S_IDLE;
        S_WAIT: begin
          resp_cnt <= resp_cnt - RESP_W'(1);
          if (resp_cnt == RESP_W'(1)) begin
            state <= S_IDLE;
          end
        end
        S_APB: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // a non-continuous count already at zero on entry is skipped and served as an interrupt
  wire logic zero_entry = state == S_FETCH && !cur_cont && cur_cnt == '0;
  assign svc_clear = (state == S_WAIT && resp_cnt == RESP_W'(1))
    || (state == S_FETCH && (cur_cont || next_cnt != '0) && !zero_entry);

  // ==========================================================================
  // core side outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_suspend <= 1'b0;
      irq_branch <= 1'b0;
      irq_addr <= '0;
      cpu_stall <= 1'b0;
      mv_out <= '0;
      trap_pend <= 1'b0;
    end else begin
      cpu_suspend <= (state == S_IDLE && (trap_pend || (win_found && !node_etu[win_idx])))
        || (state == S_WAIT && resp_cnt != RESP_W'(1)); // RULE_02
      irq_branch <= state == S_WAIT && resp_cnt == RESP_W'(1);
      if (state == S_WAIT && resp_cnt == RESP_W'(1)) begin
        irq_addr <= svc_trap ? TRAP_VECT
          : VECT_BASE + (ADDR_W'(svc_node) << VECT_SH); // RULE_02
      end
      // one stolen cycle carries the move itself
      cpu_stall <= state == S_FETCH && !zero_entry; // RULE_03
      mv_out.valid <= state == S_FETCH && !zero_entry; // RULE_04
      if (state == S_FETCH) begin
        mv_out.word <= ch_ctl[svc_chan][CC_WORD];
        mv_out.src <= mem_q[ADDR_W-1:0];
        mv_out.dst <= mem_q[2*ADDR_W-1:ADDR_W];
      end
      // a new trap wins over the clear of the one being served
      if (trap_req) begin
        trap_pend <= 1'b1; // RULE_14
      end else if (svc_clear && svc_trap) begin
        trap_pend <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // apb answer: one wait state for flop registers and pointer writes, two for pointer reads
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= (apb_go && !(!apb_in.pwrite && (hit_src || hit_dst))) || state == S_APB;
      pslverr <= apb_go && !mapped;
      if (state == S_APB) begin
        prdata <= 32'(hit_dst ? mem_q[2*ADDR_W-1:ADDR_W] : mem_q[ADDR_W-1:0]);
      end else if (apb_go && !apb_in.pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // ==========================================================================
  // router configuration
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      src_sel <= SRCSEL_RST;
      edge_cfg <= EDGE_RST;
      route <= ROUTE_RST;
      pat_cfg <= '{default: PAT_RST};
    end else if (apb_wr) begin
      if (pa == OFF_SRCSEL) src_sel <= apb_in.pwdata;
      if (pa == OFF_EDGE) edge_cfg <= apb_in.pwdata[7:0];
      if (pa == OFF_ROUTE) route <= apb_in.pwdata[15:0];
      if (hit_pat) pat_cfg[pa[3:2]] <= apb_in.pwdata[9:0];
    end
  end

  // ==========================================================================
  // external request router: sync, edge detect, matrix and gating per lane
  generate
    for (genvar k = 0; k < ERU_N; k++) begin : g_eru_lane // RULE_11
      wire logic settled = s2[k] == s3[k];
      // level only moves once two stages agree
      assign eru_evt[k] = settled && s3[k] != eru_lvl[k]
        && ((s3[k] && edge_cfg[2*k]) || (!s3[k] && edge_cfg[2*k+1])); // RULE_12
      wire logic hit = |(route[4*k +: 4] & eru_evt);
      wire logic match = ((eru_lvl ^ pat_cfg[k][PT_PAT +: 4])
        & pat_cfg[k][PT_MASK +: 4]) == 4'h0;
      wire gate_mode_e mode = gate_mode_e'(pat_cfg[k][PT_MODE +: 2]);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          s1[k] <= 1'b0;
          s2[k] <= 1'b0;
          s3[k] <= 1'b0;
          eru_lvl[k] <= 1'b0;
          eru_trig[k] <= 1'b0;
        end else begin
          s1[k] <= ext_pin[k];
          s2[k] <= s1[k];
          s3[k] <= s2[k];
          if (settled) eru_lvl[k] <= s3[k];
          eru_trig[k] <= hit && (mode == GATE_ALWAYS || (mode == GATE_MATCH && match)
            || (mode == GATE_MISS && !match)); // RULE_13
        end
      end
    end
  endgenerate

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic prio_ok;
  always_comb begin
    prio_ok = 1'b1;
    for (int i = 0; i < NODES; i++) begin
      if (node_flag[i] && node_en[i] && node_prio[i] > win_prio) prio_ok = 1'b0;
    end
  end

  sequence fetch_go;
    state == S_FETCH && !zero_entry;
  endsequence
  sequence std_take;
    state == S_IDLE && !trap_pend && win_found && !node_etu[win_idx];
  endsequence

  a_stall_single: assert property ($rose(cpu_stall) |=> !cpu_stall) // RULE_03
    else $error("stall lasted more than one cycle");
  a_move_seq: assert property (fetch_go |=> mv_out.valid && cpu_stall ##1 state == S_IDLE) // RULE_04
    else $error("move not issued in the stolen cycle");
  a_count_dec: assert property (fetch_go and !cur_cont // RULE_05
    |=> cur_cnt == $past(cur_cnt) - CNT_W'(1))
    else $error("transfer count not decremented");
  a_count_cont: assert property (fetch_go and cur_cont |=> $stable(cur_cnt)) // RULE_05
    else $error("continuous channel count changed");
  a_zero_irq: assert property (fetch_go and (!cur_cont && next_cnt == '0) // RULE_06
    |=> node_flag[svc_node] && !node_etu[svc_node])
    else $error("count zero did not fall back to interrupt");
  a_resp_fast: assert property (std_take and jump_cache |=> cpu_suspend ##6 irq_branch) // RULE_08
    else $error("fast response not 7 clocks");
  a_resp_slow: assert property (std_take and !jump_cache |=> cpu_suspend ##10 irq_branch) // RULE_08
    else $error("slow response not 11 clocks");
  a_vector_addr: assert property (irq_branch && !svc_trap
    |-> irq_addr == VECT_BASE + (ADDR_W'(svc_node) << VECT_SH)) // RULE_02
    else $error("branch to wrong vector");
  a_prio_pick: assert property (win_found |-> prio_ok) // RULE_15
    else $error("lower priority node selected");
  a_trap_first: assert property (state == S_IDLE && trap_pend |=> state == S_WAIT && svc_trap) // RULE_14
    else $error("trap not served first");
  a_flag_set: assert property (|src_evt |=> (node_flag & $past(src_evt)) == $past(src_evt)) // RULE_09
    else $error("request flag not set");

endmodule : irq_evt_system
`default_nettype wire

/* verification/core_model.sv */
// core model: follows suspend and branch, chooses jump cache use.
// assumes the same clock as the interrupt system.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock and control
  input wire logic ref_clk,
  input wire logic use_cache,
  // interrupt system side
  input wire logic cpu_suspend,
  input wire logic irq_branch,
  output logic jump_cache,
  output var int susp_len
);
  int run = 0;
  assign jump_cache = use_cache;
  // cycles lost while suspended, recorded at the branch
  always @(posedge ref_clk) begin
    if (irq_branch) susp_len <= run;
    run <= cpu_suspend ? run + 1 : 0;
  end
endmodule : core_model
`default_nettype wire

/* verification/testbench.sv */
// testbench of the interrupt and event transfer system.
// assumes the package constants and the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, e); end end
module testbench import irq_evt_pkg::*;;
  logic ref_clk = 0, nrst = 0, trap_req = 0, use_cache = 1, pready, pslverr, err;
  logic cpu_suspend, irq_branch, cpu_stall, jump_cache;
  apb_req_s apb_in = '0;
  logic [NODES-1:0] src_req = '0;
  logic [SHARED_N-1:0] shared_req = '0;
  logic [ERU_N-1:0] ext_pin = '0, eru_trig;
  logic [31:0] prdata, rd;
  logic [ADDR_W-1:0] irq_addr;
  logic [15:0] lf = 16'h0058;
  move_s mv_out, mv;
  int num_errors = 0, check_count = 0, susp_len, k, n, c;
  irq_evt_system uut (.ref_clk, .nrst, .apb_in, .prdata, .pready, .pslverr, .src_req,
    .shared_req, .trap_req, .ext_pin, .jump_cache, .cpu_suspend, .irq_branch,
    .irq_addr, .cpu_stall, .mv_out, .eru_trig);
  core_model core (.ref_clk, .use_cache, .cpu_suspend, .irq_branch, .jump_cache,
    .susp_len);
  initial forever #50 ref_clk = ~ref_clk;
  // ====
  // expectations
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] ctl(input logic [3:0] p, input logic t, input int ch);
    return {22'h0, 3'(ch), t, p, 2'b10};
  endfunction : ctl
  // ====
  // drivers: one apb transfer, request pulses, bounded event wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk) apb_in <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk) apb_in.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_in <= '0;
  endtask : apb
  task automatic pulse(input logic [NODES-1:0] m, input logic t);
    @(posedge ref_clk) src_req <= m;
    trap_req <= t;
    shared_req <= lf;
    ext_pin[3:1] <= lf[3:1];
    lf = lfsr(lf);
    @(posedge ref_clk) src_req <= '0;
    trap_req <= 1'b0;
    shared_req <= '0;
  endtask : pulse
  task automatic wait_ev(input int w, output int k);
    k = 0;
    do begin @(posedge ref_clk); k++; end while (k < 40 && !(w == 0 ? irq_branch === 1'b1
      : w == 1 ? cpu_stall === 1'b1 : eru_trig[0] === 1'b1));
    mv = mv_out;
  endtask : wait_ev
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #1000000 num_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(0, OFF_PAT, 0); `CHK(rd, {22'h0, PAT_RST})
    apb(0, 12'h1F0, 0); `CHK(err, 1'b1)
    // standard service, fast then slow response, random node and priority
    for (int i = 0; i < 2; i++) begin
      n = int'(lf[4:0]);
      use_cache <= (i == 0);
      apb(1, 12'(4 * n), ctl(lf[9:6], 0, 0));
      apb(0, 12'(4 * n), 0); `CHK(rd, ctl(lf[9:6], 0, 0))
      pulse(NODES'(1) << n, 0);
      wait_ev(0, k); `CHK(k, (i == 0 ? RESP_FAST : RESP_SLOW) + 1)
      `CHK(irq_addr, 24'(4 * n))
      apb(0, 12'(4 * n), 0); `CHK(rd[0], 1'b0)
      `CHK(susp_len, (i == 0 ? RESP_FAST : RESP_SLOW) - 1)
      apb(1, 12'(4 * n), 0);
    end
    // trap beats both nodes, then the higher priority node
    apb(1, 12'h00C, ctl(4'h2, 0, 0));
    apb(1, 12'h024, ctl(4'h9, 0, 0));
    pulse(64'h208, 1);
    wait_ev(0, k); `CHK(irq_addr, 24'h000100)
    wait_ev(0, k); `CHK(irq_addr, 24'h000024)
    wait_ev(0, k); `CHK(irq_addr, 24'h00000C)
    // transfer on a random channel: count 2, byte, source increments
    c = int'(lf[2:0]);
    apb(1, OFF_CHCTL + 12'(4 * c), 32'h202);
    apb(1, OFF_CHSRC + 12'(4 * c), 32'h1000);
    apb(1, OFF_CHDST + 12'(4 * c), 32'h2000);
    apb(1, 12'h050, ctl(4'h1, 1, c));
    pulse(NODES'(1) << 20, 0);
    wait_ev(1, k); `CHK({mv.valid, mv.word, mv.src, mv.dst}, {2'b10, 48'h001000_002000})
    @(posedge ref_clk) `CHK(cpu_stall, 1'b0)
    apb(0, OFF_CHCTL + 12'(4 * c), 0); `CHK(rd[7:0], 8'h01)
    pulse(NODES'(1) << 20, 0);
    wait_ev(1, k); `CHK({mv.src, mv.dst}, 48'h001001_002000)
    wait_ev(0, k); `CHK(irq_addr, 24'h000050)
    // continuous channel with count zero still moves and keeps its count
    apb(1, OFF_CHCTL + 12'(4 * c), 32'h800);
    apb(1, 12'h050, ctl(4'h1, 1, c));
    pulse(NODES'(1) << 20, 0);
    wait_ev(1, k); `CHK({mv.src, mv.dst}, 48'h001002_002000)
    apb(0, OFF_CHCTL + 12'(4 * c), 0); `CHK(rd, 32'h800)
    // shared node 56 follows the shared source its select nibble names
    c = int'(lf[7:4]);
    n = int'(lf[c]);
    apb(1, 12'h0E0, 0);
    apb(1, OFF_SRCSEL, 32'(c));
    pulse('0, 0);
    apb(0, 12'h0E0, 0); `CHK(rd[0], n[0])
    // router: rising edge passes gate 0, falling does not, gate off blocks
    apb(1, OFF_EDGE, 32'h1);
    apb(1, OFF_ROUTE, 32'h1);
    apb(1, OFF_PAT, 32'h0);
    ext_pin[0] <= 1'b1;
    wait_ev(2, k); `CHK(k < 40, 1'b1)
    ext_pin[0] <= 1'b0;
    wait_ev(2, k); `CHK(k, 40)
    apb(1, OFF_PAT, 32'h300);
    ext_pin[0] <= 1'b1;
    wait_ev(2, k); `CHK(k, 40)
    // pin 0 low before its edge: match mode passes, miss mode blocks
    for (int m = 1; m < 3; m++) begin
      ext_pin[0] <= 1'b0;
      wait_ev(2, k); `CHK(k, 40)
      apb(1, OFF_PAT, 32'h10 | (m << 8));
      ext_pin[0] <= 1'b1;
      wait_ev(2, k); `CHK(k < 40, m == 1)
    end
    complete_run();
  end
endmodule : testbench
`default_nettype wire
